// ===== hdl/host_port_one_second_tick.sv
// Parallel host register port with one-second divider and latch input
`timescale 1ns/1ps
`default_nettype none

module host_port_one_second_tick #(
   parameter int DIVIDE = host_port_pkg::DIVIDE_RATIO
) (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // Device pins
   input  wire logic                              device_reset_n,
   input  wire logic                              bus_timing_select,
   input  wire logic                              host_bus_clock,
   input  wire logic                              chip_select_n,
   input  wire logic                              write_not_read,
   input  wire logic                              address_strobe_n,
   input  wire logic [host_port_pkg::ADDR_W-1:0]  host_address,
   // Data bus, three signals
   input  wire logic [host_port_pkg::DATA_W-1:0]  host_data_in,
   output logic      [host_port_pkg::DATA_W-1:0]  host_data_out,
   output logic                                   host_data_oe,
   // Frame tick and one-second pin
   input  wire logic                              frame_tick_in,
   input  wire logic                              second_pulse_io_in,
   output logic                                   second_pulse_io_out,
   output logic                                   second_pulse_io_oe
);

   // Shared pins: write_not_read doubles as the read strobe, and
   // address_strobe_n doubles as the write strobe in asynchronous timing.

   host_port_pkg::host_sample_t      raw;
   host_port_pkg::host_sample_t      meta_ff;
   host_port_pkg::host_sample_t      smp_ff;
   logic [3:0]                       pin_meta_ff;
   logic [3:0]                       pin_sync_ff;
   logic                             hclk_prev_ff;
   logic                             tick_prev_ff;
   logic                             pulse_prev_ff;
   logic                             rst_any;
   logic                             hclk_rise;
   logic                             tick_rise;
   logic                             pulse_rise;
   logic                             selected;
   logic                             sync_mode;
   logic                             sync_read_req;
   logic                             sync_write_req;
   logic                             async_read_req;
   logic                             async_write_req;
   logic                             read_req;
   host_port_pkg::access_state_t     state_ff;
   host_port_pkg::access_state_t     nxt_state;
   logic [host_port_pkg::DATA_W-1:0] mode_ff;
   logic [host_port_pkg::DATA_W-1:0] second_count_ff;
   logic [host_port_pkg::DATA_W-1:0] latched_count_ff;
   logic [host_port_pkg::DATA_W-1:0] latched_status_ff;
   logic [host_port_pkg::DATA_W-1:0] read_data_ff;
   logic [host_port_pkg::DATA_W-1:0] wr_data_ff;
   logic [host_port_pkg::ADDR_W-1:0] wr_addr_ff;
   logic                             write_commit;
   logic [host_port_pkg::DATA_W-1:0] commit_data;
   logic [host_port_pkg::ADDR_W-1:0] commit_addr;
   logic [host_port_pkg::DATA_W-1:0] status_now;
   logic                             div_level;
   logic                             div_wrap;
   logic                             pulse_is_output;

   // Register read decode over the full address
   function automatic logic [host_port_pkg::DATA_W-1:0] read_mux(
      input logic [host_port_pkg::ADDR_W-1:0] addr,
      input logic [host_port_pkg::DATA_W-1:0] mode,
      input logic [host_port_pkg::DATA_W-1:0] status,
      input logic [host_port_pkg::DATA_W-1:0] count,
      input logic [host_port_pkg::DATA_W-1:0] latched);
      logic [host_port_pkg::DATA_W-1:0] value;
      value = host_port_pkg::UNMAPPED_VALUE;
      case (addr)
         host_port_pkg::MODE_OFFSET:   value = mode;
         host_port_pkg::STATUS_OFFSET: value = status;
         host_port_pkg::COUNT_OFFSET:  value = count;
         host_port_pkg::LATCH_OFFSET:  value = latched;
         default:                      value = host_port_pkg::UNMAPPED_VALUE;
      endcase
      return value;
   endfunction

   // Pin synchronisers
   assign raw = '{chip_select_n:     chip_select_n,
                  strobe_a_n:        address_strobe_n,
                  strobe_b:          write_not_read,
                  bus_timing_select: bus_timing_select,
                  host_address:      host_address,
                  host_data:         host_data_in};

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff     <= '{chip_select_n: 1'b1, strobe_a_n: 1'b1, strobe_b: 1'b1,
                          bus_timing_select: 1'b0, host_address: '0, host_data: '0};
         smp_ff      <= '{chip_select_n: 1'b1, strobe_a_n: 1'b1, strobe_b: 1'b1,
                          bus_timing_select: 1'b0, host_address: '0, host_data: '0};
         // Edge pins rest high so a pin already high gives no false edge
         pin_meta_ff <= 4'h7;
         pin_sync_ff <= 4'h7;
      end else begin
         meta_ff     <= raw;
         smp_ff      <= meta_ff;
         pin_meta_ff <= {device_reset_n, host_bus_clock, frame_tick_in, second_pulse_io_in};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Edge detectors read only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         hclk_prev_ff  <= 1'b1;
         tick_prev_ff  <= 1'b1;
         pulse_prev_ff <= 1'b1;
      end else begin
         hclk_prev_ff  <= pin_sync_ff[2];
         tick_prev_ff  <= pin_sync_ff[1];
         pulse_prev_ff <= pin_sync_ff[0];
      end
   end

   // Device reset pin held low resets every register below
   assign rst_any    = rst || !pin_sync_ff[3];
   assign hclk_rise  = pin_sync_ff[2] && !hclk_prev_ff;
   assign tick_rise  = pin_sync_ff[1] && !tick_prev_ff;
   assign pulse_rise = pin_sync_ff[0] && !pulse_prev_ff;

   // Access decode
   assign selected  = !smp_ff.chip_select_n;
   assign sync_mode = smp_ff.bus_timing_select;
   assign sync_read_req  = selected && sync_mode && !smp_ff.strobe_a_n
                           && !smp_ff.strobe_b;
   assign sync_write_req = selected && sync_mode && !smp_ff.strobe_a_n
                           && smp_ff.strobe_b && hclk_rise;
   assign async_read_req  = selected && !sync_mode && !smp_ff.strobe_b;
   assign async_write_req = selected && !sync_mode && !smp_ff.strobe_a_n
                            && smp_ff.strobe_b;
   assign read_req = sync_read_req || async_read_req;

   // Access state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         host_port_pkg::ST_IDLE: begin
            if (sync_read_req && hclk_rise) begin
               nxt_state = host_port_pkg::ST_READ;
            end else if (async_read_req) begin
               nxt_state = host_port_pkg::ST_READ;
            end else if (async_write_req) begin
               nxt_state = host_port_pkg::ST_WRITE;
            end
         end
         host_port_pkg::ST_READ: begin
            if (!read_req) begin
               nxt_state = host_port_pkg::ST_IDLE;
            end
         end
         host_port_pkg::ST_WRITE: begin
            if (!async_write_req) begin
               nxt_state = host_port_pkg::ST_IDLE;
            end
         end
         default: nxt_state = host_port_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst_any) begin
         state_ff <= host_port_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Asynchronous write holds the last data seen while the strobe is low
   always_ff @(posedge clk) begin
      if (rst_any) begin
         wr_data_ff <= '0;
         wr_addr_ff <= '0;
      end else if (async_write_req) begin
         wr_data_ff <= smp_ff.host_data;
         wr_addr_ff <= smp_ff.host_address;
      end
   end

   // Commit on the host clock rise or at the end of the write strobe while chip select is still low
   assign write_commit = sync_write_req
                         || (state_ff == host_port_pkg::ST_WRITE && !async_write_req
                             && selected);
   assign commit_data  = sync_write_req ? smp_ff.host_data : wr_data_ff;
   assign commit_addr  = sync_write_req ? smp_ff.host_address : wr_addr_ff;

   always_ff @(posedge clk) begin
      if (rst_any) begin
         mode_ff <= host_port_pkg::MODE_RESET;
      end else if (write_commit && commit_addr == host_port_pkg::MODE_OFFSET) begin
         mode_ff <= commit_data;
      end
   end

   // Read data follows the addressed register while the read stands
   assign status_now = {4'h0, latched_status_ff[host_port_pkg::STAT_LATCHED_BIT],
                        pulse_is_output, second_pulse_io_out, sync_mode};

   always_ff @(posedge clk) begin
      if (rst_any) begin
         read_data_ff <= '0;
      end else if (read_req) begin
         read_data_ff <= read_mux(smp_ff.host_address, mode_ff, status_now,
                                  second_count_ff, latched_count_ff);
      end
   end

   assign host_data_out = read_data_ff;
   assign host_data_oe  = (state_ff == host_port_pkg::ST_READ);

   // One-second divider
   assign pulse_is_output = mode_ff[host_port_pkg::MODE_DIR_BIT];

   second_divider #(
      .DIVIDE (DIVIDE)
   ) u_divider (
      .clk   (clk),
      .rst   (rst_any),
      .tick  (tick_rise),
      .level (div_level),
      .wrap  (div_wrap)
   );

   assign second_pulse_io_out = div_level;
   assign second_pulse_io_oe  = pulse_is_output;

   // Seconds counter and its snapshot on the input edge
   always_ff @(posedge clk) begin
      if (rst_any) begin
         second_count_ff <= host_port_pkg::COUNT_RESET;
      end else if (div_wrap) begin
         second_count_ff <= second_count_ff + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_any) begin
         latched_count_ff  <= host_port_pkg::COUNT_RESET;
         latched_status_ff <= '0;
      end else if (!pulse_is_output && pulse_rise) begin
         latched_count_ff  <= second_count_ff;
         latched_status_ff <= status_now | 8'h08;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_any);

   sequence s_async_write_end;
      (state_ff == host_port_pkg::ST_WRITE) ##0 (!async_write_req && selected);
   endsequence

   sequence s_sync_write_mode;
      sync_write_req ##0 (smp_ff.host_address == host_port_pkg::MODE_OFFSET);
   endsequence

   data_float_a: assert property (!selected |=> !host_data_oe)
      else $error("data driven while not selected");

   no_select_a: assert property ((!selected && hclk_rise) |=> $stable(mode_ff))
      else $error("register changed while not selected");

   sync_write_a: assert property (s_sync_write_mode |=> mode_ff == $past(smp_ff.host_data))
      else $error("synchronous write not stored");

   async_write_a: assert property (s_async_write_end ##0
      (wr_addr_ff == host_port_pkg::MODE_OFFSET) |=> mode_ff == $past(wr_data_ff))
      else $error("asynchronous write not stored");

   sync_read_a: assert property ((state_ff == host_port_pkg::ST_IDLE
      && sync_read_req && hclk_rise) |=> host_data_oe)
      else $error("synchronous read did not drive data");

   async_read_a: assert property ((state_ff == host_port_pkg::ST_IDLE
      && async_read_req && smp_ff.host_address == host_port_pkg::MODE_OFFSET)
      |=> host_data_oe ##0 host_data_out == $past(mode_ff))
      else $error("asynchronous read returned wrong data");

   pulse_dir_a: assert property (s_sync_write_mode |=>
      second_pulse_io_oe == $past(smp_ff.host_data[host_port_pkg::MODE_DIR_BIT]))
      else $error("pulse pin direction does not follow mode bit");

   latch_edge_a: assert property ((!pulse_is_output && pulse_rise) |=>
      latched_count_ff == $past(second_count_ff))
      else $error("counter not latched on input edge");

   strobe_qual_a: assert property ((sync_mode && smp_ff.strobe_a_n
      && hclk_rise && state_ff == host_port_pkg::ST_IDLE) |=> !host_data_oe)
      else $error("access taken without address strobe");

   reset_pin_a: assert property (@(posedge clk) disable iff (rst)
      !pin_sync_ff[3] |=> mode_ff == host_port_pkg::MODE_RESET && !host_data_oe)
      else $error("device reset did not clear the port");

endmodule // host_port_one_second_tick

`default_nettype wire

// ===== hdl/host_port_pkg.sv
// Shared constants and types for the host port and one-second divider
package host_port_pkg;

   // Bus widths
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] MODE_OFFSET   = 11'h200;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 11'h201;
   localparam logic [ADDR_W-1:0] COUNT_OFFSET  = 11'h202;
   localparam logic [ADDR_W-1:0] LATCH_OFFSET  = 11'h203;

   // Reset values and field positions
   localparam logic [DATA_W-1:0] MODE_RESET     = 8'h00;
   localparam logic [DATA_W-1:0] COUNT_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 8'h00;
   localparam int MODE_DIR_BIT      = 0;
   localparam int STAT_SYNC_BIT     = 0;
   localparam int STAT_PULSE_BIT    = 1;
   localparam int STAT_DIR_BIT      = 2;
   localparam int STAT_LATCHED_BIT  = 3;

   // Divider from the frame tick to one second
   localparam int DIVIDE_RATIO = 8000;
   localparam int DIVIDE_W     = 13;

   // Clock
   localparam int CLK_PERIOD_NS = 100;

   // One snapshot of the host pins after synchronisation
   typedef struct packed {
      logic              chip_select_n;
      logic              strobe_a_n;
      logic              strobe_b;
      logic              bus_timing_select;
      logic [ADDR_W-1:0] host_address;
      logic [DATA_W-1:0] host_data;
   } host_sample_t;

   // Access state machine
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } access_state_t;

endpackage

// ===== hdl/second_divider.sv
// Divides synchronised frame tick pulses down to a one-second square wave
`timescale 1ns/1ps
`default_nettype none

module second_divider #(
   parameter int DIVIDE = host_port_pkg::DIVIDE_RATIO
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Tick in
   input  wire logic tick,
   // Divided output
   output logic      level,
   output logic      wrap
);

   localparam logic [host_port_pkg::DIVIDE_W-1:0] LAST =
      host_port_pkg::DIVIDE_W'(DIVIDE - 1);
   localparam logic [host_port_pkg::DIVIDE_W-1:0] HALF =
      host_port_pkg::DIVIDE_W'(DIVIDE / 2);

   logic [host_port_pkg::DIVIDE_W-1:0] cnt_ff;
   logic                               level_ff;

   // One period per DIVIDE ticks
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
      end
   end

   // High for the first half of each period
   always_ff @(posedge clk) begin
      if (rst) begin
         level_ff <= 1'b1;
      end else if (tick && cnt_ff == LAST) begin
         level_ff <= 1'b1;
      end else if (tick && cnt_ff == HALF - 1'b1) begin
         level_ff <= 1'b0;
      end
   end

   assign level = level_ff;
   assign wrap  = tick && (cnt_ff == LAST);

   divider_wrap_a: assert property (@(posedge clk) disable iff (rst)
      (tick && cnt_ff == LAST) |=> (cnt_ff == '0 && level_ff))
      else $error("divider did not restart after the last tick");

endmodule // second_divider

`default_nettype wire

// ===== testbench/host_model.sv
// Host microprocessor model driving the parallel register port pins
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // Clock
   input  wire logic                             clk,
   // Pins driven by the host
   output var logic                              device_reset_n,
   output var logic                              bus_timing_select,
   output var logic                              host_bus_clock,
   output var logic                              chip_select_n,
   output var logic                              write_not_read,
   output var logic                              address_strobe_n,
   output var logic [host_port_pkg::ADDR_W-1:0]  host_address,
   output var logic [host_port_pkg::DATA_W-1:0]  host_data_in,
   // Read path
   input  wire logic [host_port_pkg::DATA_W-1:0] host_data_out,
   input  wire logic                             host_data_oe
);
   logic [1:0] hclk_div;

   initial begin
      device_reset_n    = 1'h0;
      bus_timing_select = 1'h0;
      host_bus_clock    = 1'h0;
      hclk_div          = 2'h0;
      chip_select_n     = 1'h1;
      write_not_read    = 1'h1;
      address_strobe_n  = 1'h1;
      host_address      = 11'h000;
      host_data_in      = 8'h00;
   end

   // Free-running host clock, period 8 clk, running before reset release
   always @(posedge clk) begin
      hclk_div <= hclk_div + 2'h1;
      if (hclk_div == 2'h3) host_bus_clock <= #1 ~host_bus_clock;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Released select and strobes go high; address and data lines show the inverse of their last value
   task automatic release_bus();
      chip_select_n    = 1'h1;
      write_not_read   = 1'h1;
      address_strobe_n = 1'h1;
      host_address     = ~host_address;
      host_data_in     = ~host_data_in;
   endtask

   task automatic set_timing(input logic sync);
      step(1);
      bus_timing_select = sync;
      step(4);
   endtask

   task automatic hold_reset(input int n);
      step(1);
      device_reset_n = 1'h0;
      step(n);
      device_reset_n = 1'h1;
      step(1);
   endtask

   // Sync accesses start after a host clock fall so exactly one rise lands inside
   task automatic start(input logic cs, input logic [10:0] addr);
      if (bus_timing_select) @(negedge host_bus_clock);
      step(1);
      chip_select_n = ~cs;
      host_address  = addr;
   endtask

   task automatic write_reg(input logic cs, input logic [10:0] addr, input logic [7:0] data);
      start(cs, addr);
      host_data_in     = data;
      write_not_read   = 1'h1;
      address_strobe_n = 1'h0;
      if (bus_timing_select) begin
         @(negedge host_bus_clock);
         step(1);
      end else begin
         step(5);
         address_strobe_n = 1'h1;
         step(4);
      end
      release_bus();
      step(4);
   endtask

   task automatic read_reg(input logic cs, input logic [10:0] addr,
                           output logic [7:0] data, output logic seen);
      int n;
      start(cs, addr);
      write_not_read   = 1'h0;
      address_strobe_n = ~bus_timing_select;
      data = 'x;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (host_data_oe !== 1'h1 && n < 16);
      seen = (host_data_oe === 1'h1);
      if (seen) data = host_data_out;
      release_bus();
      step(4);
   endtask
endmodule // host_model

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking testbench for the host port with one-second divider
`timescale 1ns/1ps
`default_nettype none

module tb;
   typedef struct packed {
      logic        sync;
      logic        wr;
      logic [10:0] addr;
      logic [7:0]  data;
   } row_t;

   logic       clk, rst, frame_tick_in, pulse_drive, bus_timing_select, host_bus_clock;
   logic       device_reset_n, chip_select_n, write_not_read, address_strobe_n;
   logic       host_data_oe, second_pulse_io_out, second_pulse_io_oe, seen;
   logic [10:0] host_address;
   logic [7:0] host_data_in, host_data_out, rd, cnt;
   wire  logic pulse_pin;
   int         fail_count, checks_done, edges;
   row_t       rows[13];

   assign pulse_pin = second_pulse_io_oe ? second_pulse_io_out : pulse_drive;

   host_model i_host (.clk(clk), .device_reset_n(device_reset_n),
      .bus_timing_select(bus_timing_select), .host_bus_clock(host_bus_clock),
      .chip_select_n(chip_select_n), .write_not_read(write_not_read),
      .address_strobe_n(address_strobe_n), .host_address(host_address),
      .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe));

   host_port_one_second_tick #(.DIVIDE(8)) i_dut (.clk(clk), .rst(rst),
      .device_reset_n(device_reset_n), .bus_timing_select(bus_timing_select),
      .host_bus_clock(host_bus_clock), .chip_select_n(chip_select_n),
      .write_not_read(write_not_read), .address_strobe_n(address_strobe_n),
      .host_address(host_address), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe),
      .frame_tick_in(frame_tick_in), .second_pulse_io_in(pulse_pin),
      .second_pulse_io_out(second_pulse_io_out), .second_pulse_io_oe(second_pulse_io_oe));

   initial clk = 1'h0;
   always #50 clk = ~clk;

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Frame ticks, counting pulse output transitions meanwhile
   task automatic ticks(input int n);
      logic prev;
      int   j;
      prev = second_pulse_io_out;
      for (j = 0; j < n * 8 + 6; j++) begin
         frame_tick_in = (j < n * 8) && (j % 8 < 4);
         i_host.step(1);
         if (second_pulse_io_out !== prev) edges++;
         prev = second_pulse_io_out;
      end
      frame_tick_in = 1'h0;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      give_verdict();
   end

   initial begin
      rows = '{'{1'h0, 1'h1, 11'h200, 8'hA5}, '{1'h0, 1'h0, 11'h200, 8'hA5},
               '{1'h0, 1'h1, 11'h100, 8'h3C}, '{1'h0, 1'h0, 11'h200, 8'hA5},
               '{1'h0, 1'h0, 11'h7FF, 8'h00}, '{1'h1, 1'h1, 11'h200, 8'h5A},
               '{1'h1, 1'h0, 11'h200, 8'h5A}, '{1'h1, 1'h1, 11'h201, 8'hFF},
               '{1'h1, 1'h0, 11'h200, 8'h5A}, '{1'h1, 1'h0, 11'h000, 8'h00},
               '{1'h1, 1'h0, 11'h201, 8'h03},
               '{1'h0, 1'h1, 11'h200, 8'h01}, '{1'h1, 1'h0, 11'h200, 8'h01}};
      rst = 1'h1;
      frame_tick_in = 1'h0;
      pulse_drive = 1'h0;
      fail_count = 0;
      checks_done = 0;
      edges = 0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'h0;
      i_host.hold_reset(5);
      check_byte("reset_outputs", 8'h01, {4'h0, host_data_oe, |host_data_out,
                 second_pulse_io_oe, second_pulse_io_out});
      foreach (rows[i]) begin
         if (bus_timing_select !== rows[i].sync) i_host.set_timing(rows[i].sync);
         if (rows[i].wr) begin
            i_host.write_reg(1'h1, rows[i].addr, rows[i].data);
            if (rows[i].addr == host_port_pkg::MODE_OFFSET)
               check_byte("pin_oe", {7'h00, rows[i].data[0]}, {7'h00, second_pulse_io_oe});
         end else begin
            i_host.read_reg(1'h1, rows[i].addr, rd, seen);
            check_byte("read_data", rows[i].data, rd);
         end
      end
      // Deselected accesses are ignored and leave the data lines floating
      i_host.write_reg(1'h0, 11'h200, 8'hF0);
      i_host.read_reg(1'h0, 11'h200, rd, seen);
      check_byte("deselected_oe", 8'h00, {7'h00, seen});
      i_host.read_reg(1'h1, 11'h200, rd, seen);
      check_byte("mode_kept", 8'h01, rd);
      // Divider: 16 ticks give two periods and four level changes
      i_host.read_reg(1'h1, 11'h202, cnt, seen);
      ticks(16);
      check_byte("pulse_edges", 8'h04, edges[7:0]);
      i_host.read_reg(1'h1, 11'h202, rd, seen);
      check_byte("second_count", cnt + 8'h02, rd);
      // Input mode: a rising edge on the pin latches the counter
      i_host.write_reg(1'h1, 11'h200, 8'h00);
      i_host.read_reg(1'h1, 11'h202, cnt, seen);
      i_host.step(4);
      pulse_drive = 1'h1;
      i_host.step(8);
      i_host.read_reg(1'h1, 11'h203, rd, seen);
      check_byte("latched_count", cnt, rd);
      i_host.read_reg(1'h1, 11'h201, rd, seen);
      check_byte("status_latched", 8'h0B, rd);
      // Device reset in mid-run returns the mode register to its reset value
      i_host.write_reg(1'h1, 11'h200, 8'h01);
      i_host.hold_reset(5);
      check_byte("pin_oe_reset", 8'h00, {7'h00, second_pulse_io_oe});
      i_host.read_reg(1'h1, 11'h200, rd, seen);
      check_byte("mode_reset", host_port_pkg::MODE_RESET, rd);
      // System reset in mid-run with the pin held high: no false latch after it
      i_host.step(1);
      rst = 1'h1;
      i_host.step(5);
      rst = 1'h0;
      i_host.step(6);
      i_host.read_reg(1'h1, 11'h201, rd, seen);
      check_byte("status_after_rst", 8'h03, rd);
      give_verdict();
   end
endmodule // tb

`default_nettype wire
